// file: rtl/pdci_top.sv
// Control logic of a powered-device interface: detection and class windows,
// class event counting, inrush sequencing and the three latched indicators.
// Assumes front-end comparator levels arrive asynchronously on i_pins and
// that software reaches the control and status words over APB.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "pdci_defines.svh"

module pdci_top #(
  parameter logic [24:0] INR_DEL_CYC = 25'(`PDCI_INR_DEL_CYC),
  parameter logic [24:0] FLT_QUAL_CYC = 25'(`PDCI_FLT_QUAL_CYC),
  parameter logic [24:0] IND_DEL_CYC = 25'(`PDCI_IND_DEL_CYC)
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rstn,
  // Register bus.
  input wire pdci_pkg::pdci_apb_req_t i_apb,
  output pdci_pkg::pdci_apb_rsp_t o_apb,
  // Front-end comparator levels.
  input wire pdci_pkg::pdci_pin_t i_pins,
  // Switch, resistor and indicator controls.
  output pdci_pkg::pdci_out_t o_ctl
);

  pdci_pkg::pdci_regs_t q;
  pdci_pkg::pdci_regs_t d;
  pdci_pkg::pdci_pin_t p;
  logic take;
  logic off_req;
  logic blank;
  logic cls_ok;
  logic [2:0] cnt_next;
  logic [1:0] tiers;

  // Filtered pin view used by all logic below.
  assign p = pdci_pkg::pdci_pin_t'(q.flt);

  // Next-state logic for the whole block.
  always_comb begin
    d = q;
    take = 1'b0;
    off_req = 1'b0;
    blank = 1'b0;
    cls_ok = 1'b0;
    cnt_next = q.count;
    tiers = 2'b11;

    // Three-stage synchroniser; a level counts once stages two and three agree.
    d.s1 = i_pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 13; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.flt[i] = q.s3[i];
      end
    end

    // APB slave: one wait state, answer registered.
    take = i_apb.psel && i_apb.penable && !q.rsp.pready;
    d.rsp.pready = take;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata = 32'h0;
    if (take) begin
      case (i_apb.paddr)
        `PDCI_OFS_CTRL: begin
          d.rsp.prdata = {31'h0, q.sw_en};
        end
        `PDCI_OFS_STAT: begin
          d.rsp.prdata = {10'h0, q.flt, 1'b0, q.ind_on, q.waive, q.type34,
                          q.count, q.state};
        end
        default: begin
          d.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // A write lands at the edge at which the master samples pready high.
    if (i_apb.psel && i_apb.penable && q.rsp.pready && i_apb.pwrite &&
        (i_apb.paddr == `PDCI_OFS_CTRL)) begin
      d.sw_en = i_apb.pwdata[`PDCI_CTRL_EN_BIT];
    end

    // Class events are counted only outside powered operation.
    cls_ok = p.vdd_cls_win && !p.aux_power_detect_in && (q.state == pdci_pkg::ST_OFF);
    d.cls_prev = cls_ok;
    if (cls_ok && !q.cls_prev) begin
      // One count per window entry, stopping at five.
      if (q.count != `PDCI_EVT_MAX) begin
        cnt_next = q.count + 3'h1;
      end
      d.count = cnt_next;
      d.type34 = p.pse_type34;
    end

    // Power-down conditions common to the inrush and powered states; aux ignores them.
    off_req = !p.vdd_above_uvlo || p.detect_disable_pin_low || p.thermal_shdn ||
              !q.sw_en;

    // Sequencer.
    case (q.state)
      pdci_pkg::ST_OFF: begin
        if (p.aux_power_detect_in && p.vdd_above_mark) begin
          d.state = pdci_pkg::ST_AUX;
        end else if (!off_req) begin
          // Input above undervoltage: start inrush with full minimum delay.
          d.state = pdci_pkg::ST_INRUSH;
          d.inr_cnt = 25'h0;
          d.waive = 1'b0;
        end
      end
      pdci_pkg::ST_INRUSH: begin
        if (q.inr_cnt != INR_DEL_CYC) begin
          d.inr_cnt = q.inr_cnt + 25'h1;
        end
        if (p.aux_power_detect_in) begin
          d.state = pdci_pkg::ST_AUX;
        end else if (off_req) begin
          d.state = pdci_pkg::ST_OFF;
        end else if (p.inrush_cur_low && (q.waive || q.inr_cnt == INR_DEL_CYC)) begin
          // Both end conditions met; fault re-entry skips the delay.
          d.state = pdci_pkg::ST_POWERED;
          d.flt_cnt = 25'h0;
          d.ind_cnt = 25'h0;
        end
      end
      pdci_pkg::ST_POWERED: begin
        if (p.rtn_fault) begin
          if (q.flt_cnt != FLT_QUAL_CYC) begin
            d.flt_cnt = q.flt_cnt + 25'h1;
          end
        end else begin
          d.flt_cnt = 25'h0;
        end
        if (p.aux_power_detect_in) begin
          d.state = pdci_pkg::ST_AUX;
        end else if (off_req) begin
          d.state = pdci_pkg::ST_OFF;
        end else if (p.rtn_fault && q.flt_cnt == FLT_QUAL_CYC) begin
          // Return pin held high too long: back to inrush, delay waived.
          d.state = pdci_pkg::ST_INRUSH;
          d.waive = 1'b1;
          d.inr_cnt = 25'h0;
        end
      end
      pdci_pkg::ST_AUX: begin
        if (!p.aux_power_detect_in) begin
          d.state = pdci_pkg::ST_OFF;
        end
      end
      default: begin
        d.state = pdci_pkg::ST_OFF;
      end
    endcase

    // Indicator delay runs only after converter release with the bias feed up;
    // the same start covers a feed that was present before inrush ended.
    blank = p.thermal_shdn || p.bias_out_uvlo || !p.vdd_above_ind;
    if (q.state != pdci_pkg::ST_POWERED || blank || !p.bias_feed_in) begin
      d.ind_cnt = 25'h0;
      d.ind_on = 1'b0;
    end else if (q.ind_cnt == IND_DEL_CYC) begin
      d.ind_on = 1'b1;
    end else begin
      d.ind_cnt = q.ind_cnt + 25'h1;
    end

    // Below mark-reset the class count, type, indicator and state are forgotten.
    if (!p.vdd_above_mark) begin
      d.count = 3'h0;
      d.type34 = 1'b0;
      d.ind_on = 1'b0;
      d.ind_cnt = 25'h0;
      d.state = pdci_pkg::ST_OFF;
    end

    // Class resistor selection inside the class window only, using the count that
    // includes the event now starting, so event three never sees the first resistor.
    d.out.class_res_first = cls_ok && (cnt_next <= `PDCI_EVT_FIRST_LAST);
    d.out.class_res_later = cls_ok && (cnt_next > `PDCI_EVT_FIRST_LAST);
    d.out.class_reg_en = cls_ok && !p.detect_disable_pin_low;
    // Detection resistor only inside the detection window.
    d.out.detect_signature_res = p.vdd_det_win && (q.state == pdci_pkg::ST_OFF);

    // Pass switch and limit follow the sequencer state.
    d.out.pass_switch_en = (q.state == pdci_pkg::ST_INRUSH) ||
                           (q.state == pdci_pkg::ST_POWERED);
    d.out.inrush_limit_en = (q.state == pdci_pkg::ST_INRUSH);

    // Converter enable: pulled low in inrush, released otherwise.
    d.out.converter_enable_out.val = 1'b0;
    d.out.converter_enable_out.oe_n = (q.state != pdci_pkg::ST_INRUSH);

    // Tier encoding from the granted event count.
    case (q.count)
      3'h2, 3'h3: tiers = 2'b10;
      3'h4: tiers = 2'b01;
      3'h5: tiers = 2'b00;
      default: tiers = 2'b11;
    endcase

    // Indicators drive the retained state while enabled.
    d.out.power_tier_hi_out.val = tiers[1];
    d.out.power_tier_lo_out.val = tiers[0];
    d.out.pse_type_out_n.val = !q.type34;
    d.out.power_tier_hi_out.oe_n = !q.ind_on;
    d.out.power_tier_lo_out.oe_n = !q.ind_on;
    d.out.pse_type_out_n.oe_n = !q.ind_on;

    // Auxiliary power overrides the indicator pins.
    if (q.state == pdci_pkg::ST_AUX) begin
      d.out.power_tier_hi_out.val = 1'b0;
      d.out.power_tier_hi_out.oe_n = 1'b0;
      d.out.power_tier_lo_out.oe_n = 1'b1;
      d.out.pse_type_out_n.oe_n = 1'b1;
      d.out.converter_enable_out.oe_n = 1'b1;
    end
  end

  // State register; pads start released and switches open.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
      q.state <= pdci_pkg::ST_OFF;
      q.sw_en <= `PDCI_CTRL_RST;
      q.out.converter_enable_out.oe_n <= 1'b1;
      q.out.power_tier_hi_out.oe_n <= 1'b1;
      q.out.power_tier_lo_out.oe_n <= 1'b1;
      q.out.pse_type_out_n.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign o_apb = q.rsp;
  assign o_ctl = q.out;

endmodule

// file: shared/pdci_defines.svh
// Offsets, field positions, reset values and timing counts of the powered-device
// sequencer. Assumes a 200 MHz core clock and 32-bit APB data words.
`ifndef PDCI_DEFINES_SVH
`define PDCI_DEFINES_SVH

`define PDCI_ADDR_W 8
`define PDCI_OFS_CTRL 8'h00
`define PDCI_OFS_STAT 8'h04
`define PDCI_CTRL_EN_BIT 0
`define PDCI_CTRL_RST 1'b1
`define PDCI_CLK_MHZ 200
`define PDCI_INR_DEL_US 81500
`define PDCI_FLT_QUAL_US 1650
`define PDCI_IND_DEL_US 24000
`define PDCI_INR_DEL_CYC (`PDCI_INR_DEL_US * `PDCI_CLK_MHZ)
`define PDCI_FLT_QUAL_CYC (`PDCI_FLT_QUAL_US * `PDCI_CLK_MHZ)
`define PDCI_IND_DEL_CYC (`PDCI_IND_DEL_US * `PDCI_CLK_MHZ)
`define PDCI_CNT_W 25
`define PDCI_EVT_MAX 3'h5
`define PDCI_EVT_FIRST_LAST 3'h2

`endif

// file: shared/pdci_pkg.sv
// Types of the powered-device sequencer: bus carriers, pins and state.
// Assumes the widths in pdci_defines.svh.
package pdci_pkg;

  typedef enum logic [1:0] {ST_OFF, ST_INRUSH, ST_POWERED, ST_AUX} pdci_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pdci_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pdci_apb_rsp_t;

  // Qualified comparator levels from the analog front end.
  typedef struct packed {
    logic thermal_shdn;
    logic bias_out_uvlo;
    logic bias_feed_in;
    logic pse_type34;
    logic rtn_fault;
    logic inrush_cur_low;
    logic detect_disable_pin_low;
    logic aux_power_detect_in;
    logic vdd_above_ind;
    logic vdd_above_uvlo;
    logic vdd_above_mark;
    logic vdd_cls_win;
    logic vdd_det_win;
  } pdci_pin_t;

  // One tri-state pin: value and active-low output enable.
  typedef struct packed {
    logic val;
    logic oe_n;
  } pdci_pad_t;

  typedef struct packed {
    logic class_res_first;
    logic class_res_later;
    logic detect_signature_res;
    logic class_reg_en;
    logic pass_switch_en;
    logic inrush_limit_en;
    pdci_pad_t converter_enable_out;
    pdci_pad_t power_tier_hi_out;
    pdci_pad_t power_tier_lo_out;
    pdci_pad_t pse_type_out_n;
  } pdci_out_t;

  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
    logic [12:0] s3;
    logic [12:0] flt;
    pdci_state_e state;
    logic [2:0] count;
    logic type34;
    logic cls_prev;
    logic [24:0] inr_cnt;
    logic [24:0] flt_cnt;
    logic [24:0] ind_cnt;
    logic waive;
    logic ind_on;
    logic sw_en;
    pdci_apb_rsp_t rsp;
    pdci_out_t out;
  } pdci_regs_t;

endpackage

// file: verification/pdci_checker.sv
// Concurrent checks on the ports of the powered-device sequencer.
// Assumes filtered pin levels reach the outputs within eight clocks.
`timescale 1ns/100ps
module pdci_checker (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rstn,
  // Register bus.
  input wire pdci_pkg::pdci_apb_req_t i_apb,
  input wire pdci_pkg::pdci_apb_rsp_t o_apb,
  // Pins and controls.
  input wire pdci_pkg::pdci_pin_t i_pins,
  input wire pdci_pkg::pdci_out_t o_ctl
);
  // All checks share the core clock and drop out during reset.
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // A level held long enough to pass the input filter.
  sequence held(s);
    s [*8];
  endsequence
  sequence aux_held;
    (i_pins.aux_power_detect_in && i_pins.vdd_above_mark) [*8];
  endsequence
  // Output relations guarded against each front-end cause.
  a_res_exclusive: assert property (!(o_ctl.class_res_first && o_ctl.class_res_later))
    else $error("both class resistors on");
  a_cls_window: assert property (held(!i_pins.vdd_cls_win) |-> !o_ctl.class_res_first
    && !o_ctl.class_res_later) else $error("class resistor outside window");
  a_cls_aux: assert property (aux_held |-> !o_ctl.class_res_first && !o_ctl.class_res_later)
    else $error("class resistor during aux power");
  a_det_window: assert property (held(!i_pins.vdd_det_win) |-> !o_ctl.detect_signature_res)
    else $error("detect resistor outside window");
  a_den_off: assert property (held(i_pins.detect_disable_pin_low) |-> !o_ctl.pass_switch_en)
    else $error("switch on while disabled");
  a_conv_inrush: assert property (o_ctl.converter_enable_out.oe_n == !o_ctl.inrush_limit_en
    && !o_ctl.converter_enable_out.val) else $error("converter enable wrong");
  a_aux_outputs: assert property (aux_held |-> !o_ctl.power_tier_hi_out.oe_n
    && !o_ctl.power_tier_hi_out.val && o_ctl.power_tier_lo_out.oe_n
    && o_ctl.pse_type_out_n.oe_n && !o_ctl.pass_switch_en) else $error("aux outputs wrong");
  a_blank_hiz: assert property (held(i_pins.thermal_shdn) |-> o_ctl.power_tier_hi_out.oe_n
    && o_ctl.power_tier_lo_out.oe_n && o_ctl.pse_type_out_n.oe_n) else $error("indicator driven");
endmodule
bind pdci_top pdci_checker i_chk (.i_clock(i_clock), .i_rstn(i_rstn), .i_apb(i_apb),
  .o_apb(o_apb), .i_pins(i_pins), .o_ctl(o_ctl));

// file: verification/pdci_pse_model.sv
// Cable-side source model: issues a commanded number of class events.
// Assumes the bench chooses the count that the requested class earns.
`timescale 1ns/100ps
module pdci_pse_model (
  // Clock, reset and command.
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_go,
  input wire logic [2:0] i_events,
  // Class window level and activity.
  output logic o_cls_win,
  output logic o_busy
);
  logic [6:0] left_q;
  // Sixteen cycles per event; the window is high in the upper half.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      left_q <= 7'h00;
    end else if (i_go) begin
      left_q <= {i_events, 4'h0};
    end else if (left_q != 7'h00) begin
      left_q <= left_q - 7'h01;
    end
  end
  // Window and busy decode.
  assign o_cls_win = left_q[3];
  assign o_busy = left_q != 7'h00;
endmodule

// file: verification/pdci_top_tb.sv
// Self-checking bench of the powered-device sequencer.
// Assumes short timer parameters so a full power-up takes tens of cycles.
`timescale 1ns/100ps
module pdci_top_tb;
  localparam int INR = 20;
  localparam int IND = 15;
  localparam int FLT = 10;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic go = 1'b0;
  logic cls;
  logic busy;
  logic [2:0] ev = 3'h0;
  pdci_pkg::pdci_apb_req_t req = '0;
  pdci_pkg::pdci_apb_rsp_t o_apb;
  pdci_pkg::pdci_pin_t pins = '0;
  pdci_pkg::pdci_pin_t pin_w;
  pdci_pkg::pdci_out_t o_ctl;
  // Design, source model and the merged pin levels.
  pdci_top #(.INR_DEL_CYC(25'(INR)), .FLT_QUAL_CYC(25'(FLT)), .IND_DEL_CYC(25'(IND))) i_dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_apb(req), .o_apb(o_apb), .i_pins(pin_w),
    .o_ctl(o_ctl));
  pdci_pse_model i_pse (.i_clock(i_clock), .i_rstn(i_rstn), .i_go(go), .i_events(ev),
    .o_cls_win(cls), .o_busy(busy));
  always_comb begin
    pin_w = pins;
    pin_w.vdd_cls_win = cls;
  end
  // Clock and hang guard.
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end
  // Compares one value and reports a mismatch.
  task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer; waits for pready and takes the answer at that edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clock);
    req.penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (o_apb.pready !== 1'b1);
    r = o_apb.prdata;
    e = o_apb.pslverr;
    req <= '0;
    @(posedge i_clock);
  endtask
  // Reset values, a read-only word and an unmapped address.
  task t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h00, 32'h0, r, e);
    chk("ctrl", 4'h1, r[3:0]);
    apb(1'b1, 8'h04, 32'hFFFFFFFF, r, e);
    apb(1'b0, 8'h04, 32'h0, r, e);
    chk("stat", 4'h0, {e, r[7], r[1:0]});
    apb(1'b1, 8'h08, 32'h1, r, e);
    chk("bad", 4'h1, {3'h0, e});
  endtask
  // Class events, power-up, indicator timing, blanking, disable and aux.
  task t_run(input logic [2:0] n);
    logic [3:0] x;
    int k;
    logic [31:0] r;
    logic e;
    pins <= '0;
    repeat (8) @(posedge i_clock);
    pins.vdd_above_mark <= 1'b1;
    pins.vdd_det_win <= 1'b1;
    pins.pse_type34 <= n[0];
    repeat (8) @(posedge i_clock);
    chk("det", 4'h1, {3'h0, o_ctl.detect_signature_res});
    pins.vdd_det_win <= 1'b0;
    ev <= n;
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
    for (k = 1; k <= n; k++) begin
      @(posedge cls);
      repeat (6) @(posedge i_clock);
      chk("res", {1'b0, 1'b1, k > 2, k < 3},
          {1'b0, o_ctl.class_reg_en, o_ctl.class_res_later, o_ctl.class_res_first});
    end
    wait (!busy);
    @(posedge i_clock);
    pins.vdd_above_uvlo <= 1'b1;
    pins.bias_feed_in <= 1'b1;
    pins.vdd_above_ind <= 1'b1;
    pins.inrush_cur_low <= 1'b1;
    k = 0;
    while (o_ctl.converter_enable_out.oe_n !== 1'b0 && k < 20) begin
      @(posedge i_clock);
      k++;
    end
    chk("inr", 4'h1, {3'h0, o_ctl.pass_switch_en});
    k = 0;
    while (o_ctl.converter_enable_out.oe_n !== 1'b1 && k < 99) begin
      @(posedge i_clock);
      k++;
    end
    chk("idly", 4'h1, {3'h0, k >= INR && k < 99});
    k = 0;
    while (o_ctl.power_tier_hi_out.oe_n !== 1'b0 && k < 99) begin
      @(posedge i_clock);
      k++;
    end
    chk("tdly", 4'h1, {3'h0, k >= IND && k < 99});
    x = n == 1 ? 4'h3 : n < 4 ? 4'h2 : n == 4 ? 4'h1 : 4'h0;
    x[2] = ~n[0];
    chk("ind", x, {1'b0, o_ctl.pse_type_out_n.val, o_ctl.power_tier_hi_out.val, o_ctl.power_tier_lo_out.val});
    // Return pin fault: qualified re-entry to inrush, then a quick waived exit.
    pins.rtn_fault <= 1'b1;
    k = 0;
    while (o_ctl.converter_enable_out.oe_n !== 1'b0 && k < 40) begin
      @(posedge i_clock);
      k++;
    end
    pins.rtn_fault <= 1'b0;
    chk("rtnq", 4'h1, {3'h0, k > FLT && k < 40});
    k = 0;
    while (o_ctl.converter_enable_out.oe_n !== 1'b1 && k < 99) begin
      @(posedge i_clock);
      k++;
    end
    chk("waive", 4'h1, {3'h0, k < INR});
    pins.thermal_shdn <= 1'b1;
    repeat (8) @(posedge i_clock);
    chk("blank", 4'h7, {1'b0, o_ctl.power_tier_hi_out.oe_n, o_ctl.power_tier_lo_out.oe_n, o_ctl.pse_type_out_n.oe_n});
    pins.thermal_shdn <= 1'b0;
    k = 0;
    while (o_ctl.power_tier_hi_out.oe_n !== 1'b0 && k < 150) begin
      @(posedge i_clock);
      k++;
    end
    chk("keep", x, {o_ctl.power_tier_hi_out.oe_n, o_ctl.pse_type_out_n.val,
        o_ctl.power_tier_hi_out.val, o_ctl.power_tier_lo_out.val});
    // Software enable cleared: power drops and the bit reads back low.
    apb(1'b1, 8'h00, 32'h0, r, e);
    apb(1'b0, 8'h00, 32'h0, r, e);
    chk("swoff", 4'h0, {2'h0, r[0], o_ctl.pass_switch_en});
    apb(1'b1, 8'h00, 32'h1, r, e);
    pins.detect_disable_pin_low <= 1'b1;
    repeat (8) @(posedge i_clock);
    chk("den", 4'h0, {3'h0, o_ctl.pass_switch_en});
    pins.aux_power_detect_in <= 1'b1;
    repeat (8) @(posedge i_clock);
    chk("aux", 4'h3, {o_ctl.power_tier_hi_out.oe_n, o_ctl.power_tier_hi_out.val, o_ctl.power_tier_lo_out.oe_n, o_ctl.pse_type_out_n.oe_n});
  endtask
  // Verdict and end of run.
  task test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence: reset, registers, then one run per event count.
  initial begin
    repeat (5) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    t_regs;
    for (int n = 1; n <= 6; n++) begin
      t_run(3'(n));
    end
    test_done;
  end
endmodule
